// ===== core/mode_reg_pkg.sv
// constants for the mode register and DLL switching block
// assumes a 50 MHz system clock that samples the memory command pins
package mode_reg_pkg;
	// axi-lite register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00; // sensor hot bit and low half of the injected command
	localparam logic [7:0] OFF_CMD = 8'h04; // command word from software
	localparam logic [7:0] OFF_MR0 = 8'h08; // mode register 0 view
	localparam logic [7:0] OFF_MR1 = 8'h0c; // mode register 1 view
	localparam logic [7:0] OFF_MR2 = 8'h10; // mode register 2 view
	localparam logic [7:0] OFF_MR3 = 8'h14; // mode register 3 view
	localparam logic [7:0] OFF_STAT = 8'h18; // decoded status
	localparam logic [7:0] OFF_TEMP = 8'h1c; // unused thermal offset: reads and writes answer slverr
	// field positions
	localparam int MR0_DLL_RST = 8;
	localparam int MR1_DLL_OFF = 0;
	localparam int MR1_WLEV = 7;
	localparam int MR1_TERM_STROBE = 11;
	localparam int MR1_QOFF = 12;
	localparam int MR2_CWL_LO = 3;
	localparam int MR2_ASR = 6;
	localparam int MR2_SRT = 7;
	localparam int MR2_RTTWR_LO = 9;
	localparam int MR3_MPR_EN = 2;
	// reset values
	localparam logic [15:0] MR_RST = 16'h0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] OUTS_RST = 16'h0703; // drivers on, mask on, bus readies up
	localparam logic [4:0] WL_RST = 5'h05; // cwl code zero plus five, no additive
	localparam logic [4:0] RL_RST = 5'h04; // cas code zero plus four, no additive
	// bank address codes for mode register set
	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [2:0] BA_MR2 = 3'h2;
	localparam logic [2:0] BA_MR3 = 3'h3;
	// command codes {ras_n,cas_n,we_n}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_SREF = 3'h1;
	// fixed calibration pattern returned in mpr mode
	localparam logic [7:0] MPR_PATTERN = 8'h55;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mode_reg_pkg

// ===== core/mode_reg_dll.sv
// mode register file, mpr redirection and dll on/off state of the memory device
// assumes command pins arrive asynchronously, are sampled on the system clock and taken on rising link clock edges
// Notes on behaviour
// - output disable bit floats all outputs
// - strobe option swaps mask for termination
// - termination strobe terminates like data strobe
// - mrs with bank two writes MR2
// - mrs with bank three writes MR3
// - partial refresh loses unselected data (MR2 A2:A0 are stored here but drive nothing)
// - write latency is additive plus cwl
// - asr picks sensor, else srt bit
// - dynamic termination off during leveling
// - mpr enable redirects reads to pattern
// - mpr page ignored when mpr off
// - nop registers nothing new
// - deselect executes no new command
// - MR1 bit zero selects dll off
// - dll off supports cl six cwl six
// - dll off read strobe one cycle earlier
// - dll reset bit clears itself
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module mode_reg_dll
	import mode_reg_pkg::*;
#(
	parameter int AW = 8 // axi address width
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic LINK_CK, // memory command clock, sampled
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [2:0] BA,
	input wire logic [15:0] ADDR,
	input wire logic [AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic OUT_EN, // data and strobe drivers enabled
	output logic MASK_EN, // shared pin acts as write mask
	output logic TSTROBE_TERM_EN, // termination strobe pair terminated
	output logic DYN_TERM_EN, // dynamic write termination active
	output logic DLL_OFF, // dll off mode
	output logic MPR_MODE, // reads return calibration pattern
	output logic SELF_REF_FAST, // high self refresh rate
	output logic [4:0] WRITE_LAT, // additive plus cas write latency
	output logic [4:0] READ_STROBE_LAT, // cycles to read strobe reference
	output logic [7:0] READ_DATA, // data of last read
	output logic READ_PULSE // one cycle per read taken
);
	// synchroniser for link clock and command pins: three stages
	localparam int SW = 24;
	logic [SW-1:0] s1_r, s2_r, s3_r;
	logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt;
	// mode registers
	logic [15:0] mr0_r, mr1_r, mr2_r, mr3_r;
	logic [15:0] mr0_nxt, mr1_nxt, mr2_nxt, mr3_nxt;
	// software control: bit0 sensor hot, bit1 unused; cmd injection
	logic [31:0] ctrl_r, ctrl_nxt;
	logic in_sref_r, in_sref_nxt; // self refresh state
	logic [7:0] rdata_r, rdata_nxt;
	logic rpulse_r, rpulse_nxt;
	// axi state
	logic aw_r, w_r, bv_r, rv_r;
	logic aw_nxt, w_nxt, bv_nxt, rv_nxt;
	logic [AW-1:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	// output registers
	logic [15:0] outs_r, outs_nxt;
	logic [4:0] wl_r, wl_nxt, rl_r, rl_nxt;

	// additive latency from MR1 A4:A3 with cas latency from MR0
	function automatic logic [4:0] add_lat(input logic [15:0] m1, input logic [4:0] cl);
		unique case (m1[4:3])
			2'h1: add_lat = cl - 5'h1;
			2'h2: add_lat = cl - 5'h2;
			default: add_lat = 5'h0; // reserved code treated as disabled
		endcase
	endfunction : add_lat

	// cas latency from MR0 A6:A4 (plus A2), coded as cl-4
	function automatic logic [4:0] cas_lat(input logic [15:0] m0);
		cas_lat = 5'(m0[6:4]) + 5'(m0[2] ? 8 : 0) + 5'h4;
	endfunction : cas_lat

	// pin sampling
	always_comb begin
		s1_nxt = {LINK_CK, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// decoded fields: a link edge is a rising level seen stably in stages two/three
	logic link_rise;
	logic c_cs_n;
	logic [2:0] c_cmd, c_ba;
	logic [15:0] c_a;
	assign link_rise = s2_r[23] && !s3_r[23];
	assign c_cs_n = s2_r[22];
	assign c_cmd = s2_r[21:19];
	assign c_ba = s2_r[18:16];
	assign c_a = s2_r[15:0];

	// command decode, mode register update and axi slave
	always_comb begin
		logic cmd_take;
		logic [2:0] cmd;
		logic [2:0] ba;
		logic [15:0] a;
		logic [4:0] cl, al, cwl;
		// latencies from the registered mode words, overridden below in dll off
		cl = cas_lat(mr0_r);
		al = add_lat(mr1_r, cl);
		cwl = 5'(mr2_r[5:3]) + 5'h5;
		cmd_take = 1'b0;
		cmd = c_cmd;
		ba = c_ba;
		a = c_a;
		mr0_nxt = mr0_r;
		mr1_nxt = mr1_r;
		mr2_nxt = mr2_r;
		mr3_nxt = mr3_r;
		ctrl_nxt = ctrl_r;
		in_sref_nxt = in_sref_r;
		rdata_nxt = rdata_r;
		rpulse_nxt = 1'b0;
		aw_nxt = aw_r;
		w_nxt = w_r;
		bv_nxt = bv_r;
		rv_nxt = rv_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		bresp_nxt = bresp_r;
		rresp_nxt = rresp_r;
		// dll reset is one shot: cleared the cycle after it was written
		mr0_nxt[MR0_DLL_RST] = 1'b0;
		// deselect and nop register nothing; state simply holds
		if (link_rise && !c_cs_n && c_cmd != CMD_NOP)
			cmd_take = 1'b1;
		// software injected command takes the place of a pin command
		if (ctrl_r[31]) begin
			cmd_take = 1'b1;
			cmd = ctrl_r[30:28];
			ba = ctrl_r[26:24];
			a = ctrl_r[15:0];
			ctrl_nxt[31] = 1'b0;
		end
		if (cmd_take) begin
			unique case (cmd)
				CMD_MRS: begin
					in_sref_nxt = 1'b0;
					unique case (ba)
						BA_MR0: mr0_nxt = a;
						BA_MR1: mr1_nxt = a;
						BA_MR2: mr2_nxt = a;
						BA_MR3: mr3_nxt = a;
						default: ;
					endcase
				end
				CMD_SREF: in_sref_nxt = 1'b1;
				CMD_READ: begin
					rpulse_nxt = 1'b1;
					// page field matters only while mpr is on
					rdata_nxt = mr3_r[MR3_MPR_EN] ? (MPR_PATTERN >> mr3_r[1:0])
						: 8'h00;
				end
				default: ;
			endcase
		end
		// dll off runs only cl 6 and cwl 6
		if (mr1_r[MR1_DLL_OFF]) begin
			cl = 5'h6;
			cwl = 5'h6;
			al = add_lat(mr1_r, cl);
		end
		wl_nxt = al + cwl;
		rl_nxt = mr1_r[MR1_DLL_OFF] ? al + cl - 5'h1 : al + cl;
		outs_nxt = '0;
		outs_nxt[0] = !mr1_r[MR1_QOFF];
		outs_nxt[1] = !mr1_r[MR1_TERM_STROBE];
		// same termination behaviour as the data strobe, never a strobe output
		outs_nxt[2] = mr1_r[MR1_TERM_STROBE] && !mr1_r[MR1_QOFF];
		outs_nxt[3] = (mr2_r[10:9] != 2'h0) && !mr1_r[MR1_WLEV];
		outs_nxt[4] = mr1_r[MR1_DLL_OFF];
		outs_nxt[5] = mr3_r[MR3_MPR_EN];
		// sensor decides when asr set, srt bit otherwise
		outs_nxt[6] = mr2_r[MR2_ASR] ? ctrl_r[0] : mr2_r[MR2_SRT];
		outs_nxt[7] = in_sref_r;
		// axi write channels, taken in either order
		if (S_AXI_AWVALID && !aw_r && !bv_r) begin
			aw_nxt = 1'b1;
			awa_nxt = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_r && !bv_r) begin
			w_nxt = 1'b1;
			wd_nxt = S_AXI_WDATA;
		end
		if (aw_r && w_r) begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			unique case (awa_r[7:0])
				OFF_CTRL: ctrl_nxt[15:0] = wd_r[15:0];
				OFF_CMD: ctrl_nxt[31:16] = {1'b1, wd_r[30:16]};
				default: bresp_nxt = RESP_SLVERR;
			endcase
			if (awa_r[7:0] == OFF_CMD)
				ctrl_nxt[15:0] = wd_r[15:0];
		end
		if (bv_r && S_AXI_BREADY)
			bv_nxt = 1'b0;
		// axi read
		if (S_AXI_ARVALID && !rv_r) begin
			rv_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (S_AXI_ARADDR[7:0])
				OFF_CTRL: rd_nxt = {16'h0000, ctrl_r[15:0]};
				OFF_CMD: rd_nxt = ctrl_r;
				OFF_MR0: rd_nxt = {16'h0000, mr0_r};
				OFF_MR1: rd_nxt = {16'h0000, mr1_r};
				OFF_MR2: rd_nxt = {16'h0000, mr2_r};
				OFF_MR3: rd_nxt = {16'h0000, mr3_r};
				OFF_STAT: rd_nxt = {6'h00, rl_r, wl_r, rdata_r, outs_r[7:0]};
				default: begin
					rd_nxt = 32'h0000_0000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (rv_r && S_AXI_RREADY)
			rv_nxt = 1'b0;
		outs_nxt[8] = !aw_nxt && !bv_nxt; // readies from next state: ports stay pure flops
		outs_nxt[9] = !w_nxt && !bv_nxt;
		outs_nxt[10] = !rv_nxt;
	end

	// state registers
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			mr0_r <= MR_RST;
			mr1_r <= MR_RST;
			mr2_r <= MR_RST;
			mr3_r <= MR_RST;
			ctrl_r <= CTRL_RST;
			in_sref_r <= 1'b0;
			rdata_r <= 8'h00;
			rpulse_r <= 1'b0;
			aw_r <= 1'b0;
			w_r <= 1'b0;
			bv_r <= 1'b0;
			rv_r <= 1'b0;
			awa_r <= '0;
			wd_r <= 32'h0000_0000;
			rd_r <= 32'h0000_0000;
			bresp_r <= RESP_OKAY;
			rresp_r <= RESP_OKAY;
			outs_r <= OUTS_RST;
			wl_r <= WL_RST;
			rl_r <= RL_RST;
		end else begin
			mr0_r <= mr0_nxt;
			mr1_r <= mr1_nxt;
			mr2_r <= mr2_nxt;
			mr3_r <= mr3_nxt;
			ctrl_r <= ctrl_nxt;
			in_sref_r <= in_sref_nxt;
			rdata_r <= rdata_nxt;
			rpulse_r <= rpulse_nxt;
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			bv_r <= bv_nxt;
			rv_r <= rv_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			bresp_r <= bresp_nxt;
			rresp_r <= rresp_nxt;
			outs_r <= outs_nxt;
			wl_r <= wl_nxt;
			rl_r <= rl_nxt;
		end
	end

	// ports straight from flops
	assign S_AXI_AWREADY = outs_r[8];
	assign S_AXI_WREADY = outs_r[9];
	assign S_AXI_BVALID = bv_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = outs_r[10];
	assign S_AXI_RVALID = rv_r;
	assign S_AXI_RDATA = rd_r;
	assign S_AXI_RRESP = rresp_r;
	assign OUT_EN = outs_r[0];
	assign MASK_EN = outs_r[1];
	assign TSTROBE_TERM_EN = outs_r[2];
	assign DYN_TERM_EN = outs_r[3];
	assign DLL_OFF = outs_r[4];
	assign MPR_MODE = outs_r[5];
	assign SELF_REF_FAST = outs_r[6];
	assign WRITE_LAT = wl_r;
	assign READ_STROBE_LAT = rl_r;
	assign READ_DATA = rdata_r;
	assign READ_PULSE = rpulse_r;
endmodule : mode_reg_dll

// ===== verif/mode_reg_dll_monitor.sv
// checker for mode register outputs and register bus handshakes
// assumes one clock domain, bound into mode_reg_dll
`timescale 1ns/100ps
module mode_reg_dll_monitor (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic LINK_CK,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic OUT_EN,
	input wire logic MASK_EN,
	input wire logic TSTROBE_TERM_EN,
	input wire logic DLL_OFF,
	input wire logic [4:0] WRITE_LAT,
	input wire logic [4:0] READ_STROBE_LAT,
	input wire logic READ_PULSE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	logic lk_r; // link clock one cycle ago
	logic [3:0] cnt_r; // cycles since the link clock last moved
	logic [3:0] cnt_nxt;
	// saturating count, so a long idle never wraps back to zero
	always_comb begin
		cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
		if (!RST_N || LINK_CK != lk_r) cnt_nxt = 4'h0;
	end
	// registers only
	always_ff @(posedge CLOCK) begin
		lk_r <= LINK_CK;
		cnt_r <= cnt_nxt;
	end
	sequence wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence b_wait;
		S_AXI_BVALID && !S_AXI_BREADY;
	endsequence
	rst_vals_a: assert property ($rose(RST_N) |-> OUT_EN && MASK_EN
		&& WRITE_LAT == 5'h05 && READ_STROBE_LAT == 5'h04) else $error("bad reset outputs");
	strobe_mask_a: assert property (OUT_EN |-> MASK_EN != TSTROBE_TERM_EN)
		else $error("mask and strobe clash");
	out_float_a: assert property (!OUT_EN |-> !TSTROBE_TERM_EN)
		else $error("strobe on while outputs off");
	dll_lat_a: assert property (DLL_OFF |-> READ_STROBE_LAT == WRITE_LAT - 5'h01)
		else $error("dll off latency wrong");
	pulse_one_a: assert property (READ_PULSE |=> !READ_PULSE)
		else $error("read pulse too long");
	idle_quiet_a: assert property (cnt_r > 4'h9 |-> !READ_PULSE)
		else $error("read without command");
	bresp_hold_a: assert property (b_wait |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
	rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	wr_answer_a: assert property (wr_taken |-> ##2 S_AXI_BVALID) else $error("write answer late");
endmodule : mode_reg_dll_monitor
bind mode_reg_dll mode_reg_dll_monitor mon_u (.*);

// ===== verif/mem_ctrl_model.sv
// behavioural memory controller on the command pins
// assumes the bench clock paces it; link clock runs only inside a command
`timescale 1ns/100ps
module mem_ctrl_model (
	input wire logic clock,
	output logic link_ck,
	output logic cs_n,
	output logic [2:0] op,
	output logic [2:0] ba,
	output logic [15:0] addr
);
	import mode_reg_pkg::*;
	initial begin
		link_ck = 1'b0;
		cs_n = 1'b1;
		op = CMD_NOP;
		ba = 3'h0;
		addr = 16'h0;
	end
	// one command across one 160 ns link clock period
	task automatic cmd(input logic c, input logic [2:0] o, input logic [2:0] b, input logic [15:0] a);
		@(posedge clock);
		cs_n <= c;
		op <= o;
		ba <= b;
		addr <= a;
		repeat (2) @(posedge clock);
		link_ck <= 1'b1;
		repeat (4) @(posedge clock);
		link_ck <= 1'b0;
		// four cycles low before the next call raises it: 160 ns per command
		repeat (1) @(posedge clock);
		// released pins show the inverse, so stale values cannot pass
		cs_n <= 1'b1;
		op <= ~o;
		ba <= ~b;
		addr <= ~a;
	endtask : cmd
	// mode register set with reserved bits forced low
	task automatic mrs(input logic [2:0] b, input logic [15:0] a);
		logic [15:0] m;
		m = 16'h1fff;
		if (b == BA_MR1) m = 16'h1aff;
		if (b == BA_MR2) m = 16'h06ff;
		if (b == BA_MR3) m = 16'h0007;
		cmd(1'b0, CMD_MRS, b, a & m);
	endtask : mrs
	// dll switch through self refresh; cke is held high by having no exit pin
	task automatic dll_switch(input logic off);
		if (off) mrs(BA_MR1, 16'h0001);
		cmd(1'b0, CMD_SREF, 3'h0, 16'h0);
		repeat (8) @(posedge clock);
		if (!off) mrs(BA_MR1, 16'h0000);
		if (!off) mrs(BA_MR0, 16'h0100);
		mrs(BA_MR0, 16'h0020);
		mrs(BA_MR2, 16'h0008);
	endtask : dll_switch
endmodule : mem_ctrl_model

// ===== verif/mode_reg_dll_tb.sv
// self-checking bench for the mode register block
// assumes the controller model drives the command pins
`timescale 1ns/100ps
module mode_reg_dll_tb;
	import mode_reg_pkg::*;
	logic clk, rst_n, lk, cs_n, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv;
	logic oe, mk, ts, dt, doff, mpr, srf, rp;
	logic [2:0] op, ba;
	logic [15:0] addr;
	logic [7:0] aw, ar, rd;
	logic [31:0] wd, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [4:0] wl, rl;
	int n_fail, checked, np;
	mem_ctrl_model m (.clock(clk), .link_ck(lk), .cs_n(cs_n), .op(op), .ba(ba), .addr(addr));
	mode_reg_dll dut_u (.CLOCK(clk), .RST_N(rst_n), .LINK_CK(lk), .CS_N(cs_n), .RAS_N(op[2]),
		.CAS_N(op[1]), .WE_N(op[0]), .BA(ba), .ADDR(addr), .S_AXI_AWADDR(aw),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.OUT_EN(oe), .MASK_EN(mk), .TSTROBE_TERM_EN(ts), .DYN_TERM_EN(dt), .DLL_OFF(doff),
		.MPR_MODE(mpr), .SELF_REF_FAST(srf), .WRITE_LAT(wl), .READ_STROBE_LAT(rl),
		.READ_DATA(rd), .READ_PULSE(rp));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// count read pulses as they pass
	always @(posedge clk) if (rp === 1'b1) np++;
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task test_done;
		if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task tmo(input int i);
		if (i >= 60) begin
			n_fail++;
			test_done;
		end
	endtask : tmo
	task axi_wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		// let an edge pass so a back-to-back call never drives a strobe twice at once
		@(posedge clk);
		aw <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		r = bresp;
		br <= 1'b0;
		tmo(i);
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		int i;
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		d = rdata;
		r = rresp;
		rr <= 1'b0;
		tmo(i);
	endtask : axi_rd
	task s_reset;
		chk({oe, mk, ts, wl, rl}, {3'b110, 5'h05, 5'h04});
		axi_rd(8'h20);
		chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
	endtask : s_reset
	task s_mr1;
		m.mrs(BA_MR1, 16'h1000);
		chk(oe, 1'b0);
		m.mrs(BA_MR1, 16'h0800);
		chk({oe, mk, ts}, 3'b101);
		axi_rd(OFF_MR1);
		chk(d, 32'h800);
	endtask : s_mr1
	task s_lat;
		for (int c = 0; c < 8; c++) begin
			m.mrs(BA_MR2, 16'(c) << 3);
			chk(wl, 5'(c + 5));
		end
		m.mrs(BA_MR1, 16'h0008);
		chk({wl, rl}, {5'h0f, 5'h07});
		m.mrs(BA_MR1, 16'h0000);
	endtask : s_lat
	task s_misc;
		m.mrs(BA_MR2, 16'h0080);
		chk(srf, 1'b1);
		axi_wr(OFF_CTRL, 32'h1);
		m.mrs(BA_MR2, 16'h02c0);
		chk({srf, dt}, 2'b11);
		axi_wr(OFF_CTRL, 32'h0);
		m.mrs(BA_MR1, 16'h0080);
		chk({srf, dt}, 2'b00);
		m.mrs(BA_MR2, 16'h0010);
		m.cmd(1'b1, CMD_MRS, BA_MR2, 16'h0028);
		chk(wl, 5'h07);
		m.cmd(1'b0, CMD_NOP, BA_MR2, 16'h0028);
		chk(wl, 5'h07);
		m.mrs(BA_MR1, 16'h0000);
	endtask : s_misc
	task s_mpr;
		m.mrs(BA_MR3, 16'h0005);
		chk(mpr, 1'b1);
		m.cmd(1'b0, CMD_READ, 3'h0, 16'h0);
		chk({np[7:0], rd}, {8'h01, 8'h2a});
		m.mrs(BA_MR3, 16'h0003);
		m.cmd(1'b0, CMD_READ, 3'h0, 16'h0);
		chk({mpr, np[7:0], rd}, {1'b0, 8'h02, 8'h00});
	endtask : s_mpr
	task s_dll;
		m.dll_switch(1'b1);
		chk({doff, wl, rl}, {1'b1, 5'h06, 5'h05});
		m.dll_switch(1'b0);
		m.mrs(BA_MR0, 16'h0120);
		axi_rd(OFF_MR0);
		chk(d, 32'h0000_0020);
		chk({doff, wl, rl}, {1'b0, 5'h06, 5'h06});
	endtask : s_dll
	// software command injection, status word and write responses
	task s_inject;
		axi_wr(OFF_CMD, 32'h1000_0000);
		chk(r, RESP_OKAY);
		axi_rd(OFF_STAT);
		chk(d, {6'h00, 5'h06, 5'h06, 8'h00, 8'h83});
		axi_wr(OFF_CMD, 32'h0200_0018);
		axi_rd(OFF_STAT);
		chk(d, {6'h00, 5'h06, 5'h08, 8'h00, 8'h03});
		axi_wr(OFF_MR0, 32'h0000_0001);
		chk(r, RESP_SLVERR);
	endtask : s_inject
	initial begin
		{rst_n, awv, wv, br, arv, rr, aw, ar, wd} = '0;
		{n_fail, checked, np} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		s_reset;
		s_mr1;
		s_lat;
		s_misc;
		s_mpr;
		s_dll;
		s_inject;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		s_reset;
		test_done;
	end
endmodule : mode_reg_dll_tb
